/* File: rtl/pcstk_top.v */
// program counter with high-byte latch and 8-level circular return stack
`timescale 1ns/1ps
`include "pcstk_consts.vh"

module pcstk_top #(
  parameter PC_W = `PCSTK_PC_W,
  parameter DEPTH = `PCSTK_DEPTH,
  parameter PTR_W = `PCSTK_PTR_W
) (
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // decoder side
  input wire step,
  input wire call_instr,
  input wire unconditional_jump_instr,
  input wire [`PCSTK_OPND_W-1:0] opnd,
  input wire irq_vector,
  input wire [PC_W-1:0] vector_addr,
  input wire return_instr,
  input wire exit_with_literal_instr,
  input wire interrupt_exit_instr,
  input wire low_wr,
  input wire [`PCSTK_LOW_W-1:0] low_wr_data,
  input wire latch_wr,
  input wire [`PCSTK_LATCH_W-1:0] latch_wr_data,
  output reg [PC_W-1:0] fetch_addr,
  output reg [`PCSTK_LOW_W-1:0] pc_low_byte,
  output reg [`PCSTK_LATCH_W-1:0] pc_high_latch
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  reg [PC_W-1:0] pc_r; // live program counter
  reg [PC_W-1:0] pc_nxt;
  reg [`PCSTK_LATCH_W-1:0] latch_r; // high-byte latch
  reg [`PCSTK_LATCH_W-1:0] latch_nxt;
  reg [PTR_W-1:0] sp_r; // internal pointer, next free slot
  reg [PTR_W-1:0] sp_nxt;
  reg run_r; // software run enable
  reg pop_pend_r; // pop waiting on registered stack read
  reg soft_clr_r; // software reset pulse, delayed one cycle
  wire [PC_W-1:0] top_data; // registered stack read data
  reg push; // push this cycle
  reg pop; // pop requested this cycle

  // apb decode helpers
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire apb_rd = apb_acc & ~pwrite;

  // address match used by read and write decode
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  wire bus_low_wr = apb_wr & hit(paddr, `PCSTK_OFF_LOW);
  wire bus_latch_wr = apb_wr & hit(paddr, `PCSTK_OFF_LATCH);
  wire bus_ctrl_wr = apb_wr & hit(paddr, `PCSTK_OFF_CTRL);
  wire mapped = hit(paddr, `PCSTK_OFF_LOW) | hit(paddr, `PCSTK_OFF_LATCH) |
                hit(paddr, `PCSTK_OFF_STAT) | hit(paddr, `PCSTK_OFF_CTRL);

  // --------------------------------------------------------------
  // shared decode functions
  // --------------------------------------------------------------
  // call and jump share one target: latch bits 4:3 above the operand
  function [PC_W-1:0] far_target;
    input [`PCSTK_LATCH_W-1:0] lat;
    input [`PCSTK_OPND_W-1:0] arg;
    begin
      far_target = {lat[`PCSTK_LATCH_W-1:`PCSTK_LATCH_TOP_LSB], arg};
    end
  endfunction

  // pointer moves one slot up or down and wraps, so overflow is silent;
  // the wrap matches the depth only while depth is two to the pointer width
  function [PTR_W-1:0] ptr_move;
    input [PTR_W-1:0] ptr;
    input up;
    begin
      if (up) begin
        ptr_move = ptr + {{(PTR_W-1){1'b0}}, 1'b1};
      end else begin
        ptr_move = ptr - {{(PTR_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // --------------------------------------------------------------
  // stack memory
  // --------------------------------------------------------------
  // read address is always the top entry so pop data is ready next cycle
  // eight 13-bit entries, outside program and data space
  pcstk_ram #(
    .DEPTH(DEPTH),
    .AW(PTR_W),
    .DW(PC_W)
  ) u_ram (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(push),
    .wr_addr(sp_r),
    .wr_data(pc_r),
    .rd_addr(ptr_move(sp_r, 1'b0)),
    .rd_data(top_data)
  );

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------
  // priority: pending pop, vector, call, jump, low write, return, step
  always @* begin
    pc_nxt = pc_r;
    latch_nxt = latch_r;
    sp_nxt = sp_r;
    push = 1'b0;
    pop = 1'b0;
    // latch writes from decoder or bus, never from push or pop
    if (latch_wr) begin
      latch_nxt = latch_wr_data;
    end else if (bus_latch_wr) begin
      latch_nxt = pwdata[`PCSTK_LATCH_W-1:0];
    end
    if (pop_pend_r) begin
      pc_nxt = top_data;
    end else if (run_r) begin
      if (irq_vector) begin
        push = 1'b1;
        sp_nxt = ptr_move(sp_r, 1'b1);
        pc_nxt = vector_addr;
      end else if (call_instr) begin
        push = 1'b1;
        sp_nxt = ptr_move(sp_r, 1'b1);
        pc_nxt = far_target(latch_r, opnd);
      end else if (unconditional_jump_instr) begin
        pc_nxt = far_target(latch_r, opnd);
      end else if (low_wr) begin
        pc_nxt = {latch_r, low_wr_data};
      end else if (return_instr | exit_with_literal_instr | interrupt_exit_instr) begin
        pop = 1'b1;
        sp_nxt = ptr_move(sp_r, 1'b0);
      end else if (step) begin
        pc_nxt = pc_r + `PCSTK_PC_ONE;
      end
    end
    // bus write to low byte: upper bits come only from the latch
    if (bus_low_wr) begin
      pc_nxt = {latch_r, pwdata[`PCSTK_LOW_W-1:0]};
    end
    // soft reset wins over everything, so outputs clear with the state
    if (soft_clr_r) begin
      pc_nxt = `PCSTK_PC_RST;
      latch_nxt = `PCSTK_LATCH_RST;
      sp_nxt = `PCSTK_PTR_RST;
      push = 1'b0;
      pop = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // state registers
  // --------------------------------------------------------------
  // no overflow or underflow flag exists; pointer just wraps
  // stack entries themselves keep their contents through any reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= `PCSTK_PC_RST;
      latch_r <= `PCSTK_LATCH_RST;
      sp_r <= `PCSTK_PTR_RST;
      pop_pend_r <= 1'b0;
    end else if (soft_clr_r) begin
      pc_r <= `PCSTK_PC_RST;
      latch_r <= `PCSTK_LATCH_RST;
      sp_r <= `PCSTK_PTR_RST;
      pop_pend_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      latch_r <= latch_nxt;
      sp_r <= sp_nxt;
      pop_pend_r <= pop;
    end
  end

  // --------------------------------------------------------------
  // control register
  // --------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b1;
      soft_clr_r <= 1'b0;
    end else begin
      // soft reset is a one-cycle pulse that clears the state next edge;
      // it leaves the run enable alone, which the same write sets
      soft_clr_r <= bus_ctrl_wr & pwdata[`PCSTK_CTRL_SRST];
      if (bus_ctrl_wr) begin
        run_r <= pwdata[`PCSTK_CTRL_RUN];
      end
    end
  end

  // --------------------------------------------------------------
  // apb answer, zero wait states
  // --------------------------------------------------------------
  // stack pointer never appears on the bus
  // the setup cycle is decoded here and answered one edge later,
  // so pready, prdata and pslverr stand for exactly the access cycle;
  // a write itself lands at the access edge in the next-state logic
  // unmapped offsets answer with pslverr and read as zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h00000000;
      if (psel & ~penable & ~pwrite) begin
        if (hit(paddr, `PCSTK_OFF_LOW)) begin
          prdata <= {24'h000000, pc_r[`PCSTK_LOW_W-1:0]};
        end else if (hit(paddr, `PCSTK_OFF_LATCH)) begin
          prdata <= {27'h0000000, latch_r};
        end else if (hit(paddr, `PCSTK_OFF_STAT)) begin
          prdata <= {30'h00000000, pop_pend_r, run_r};
        end else if (hit(paddr, `PCSTK_OFF_CTRL)) begin
          prdata <= {31'h00000000, run_r};
        end
      end
    end
  end

  // --------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_addr <= `PCSTK_PC_RST;
      pc_low_byte <= 8'h00;
      pc_high_latch <= `PCSTK_LATCH_RST;
    end else begin
      // outputs follow the next value so they match the state registers
      // cycle for cycle, soft reset included
      fetch_addr <= pc_nxt;
      pc_low_byte <= pc_nxt[`PCSTK_LOW_W-1:0];
      pc_high_latch <= latch_nxt;
    end
  end

endmodule

/* File: rtl/pcstk_consts.vh */
// constants for the program counter and return-address stack
`ifndef PCSTK_CONSTS_VH
`define PCSTK_CONSTS_VH

// apb register byte offsets
`define PCSTK_OFF_LOW 12'h000
`define PCSTK_OFF_LATCH 12'h004
`define PCSTK_OFF_STAT 12'h008
`define PCSTK_OFF_CTRL 12'h00C

// widths and field positions
`define PCSTK_PC_W 13
`define PCSTK_LOW_W 8
`define PCSTK_UP_W 5
`define PCSTK_LATCH_W 5
`define PCSTK_LATCH_TOP_LSB 3
`define PCSTK_OPND_W 11
`define PCSTK_DEPTH 8
`define PCSTK_PTR_W 3

// reset values and the pc step increment
`define PCSTK_PC_RST 13'h0000
`define PCSTK_LATCH_RST 5'h00
`define PCSTK_PTR_RST 3'h0
`define PCSTK_PC_ONE 13'h0001

// control register bits
`define PCSTK_CTRL_RUN 0
`define PCSTK_CTRL_SRST 1

`endif

/* File: rtl/pcstk_ram.v */
// return-address storage: small memory with registered read data
`timescale 1ns/1ps
`include "pcstk_consts.vh"

module pcstk_ram #(
  parameter DEPTH = `PCSTK_DEPTH,
  parameter AW = `PCSTK_PTR_W,
  parameter DW = `PCSTK_PC_W
) (
  input wire pclk,
  input wire presetn,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:DEPTH-1]; // entries, no reset needed

  // --------------------------------------------------------------
  // write port
  // --------------------------------------------------------------
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // --------------------------------------------------------------
  // registered read port
  // --------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= `PCSTK_PC_RST;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

/* File: sim/pcstk_dec.sv */
// decoder model: one request code becomes one strobe toward the block
`timescale 1ns/1ps
module pcstk_dec (
  input wire [3:0] op,
  input wire [12:0] arg,
  output wire step,
  output wire call_instr,
  output wire unconditional_jump_instr,
  output wire [10:0] opnd,
  output wire irq_vector,
  output wire [12:0] vector_addr,
  output wire return_instr,
  output wire exit_with_literal_instr,
  output wire interrupt_exit_instr,
  output wire low_wr,
  output wire [7:0] low_wr_data,
  output wire latch_wr,
  output wire [4:0] latch_wr_data
);
  // idle data lines show the inverse, never the last value
  wire [12:0] d = (op != 4'h0) ? arg : ~arg;
  assign step = (op == 4'h1);
  assign call_instr = (op == 4'h2);
  assign unconditional_jump_instr = (op == 4'h3);
  assign irq_vector = (op == 4'h4);
  assign return_instr = (op == 4'h5);
  assign exit_with_literal_instr = (op == 4'h6);
  assign interrupt_exit_instr = (op == 4'h7);
  assign low_wr = (op == 4'h8);
  assign latch_wr = (op == 4'h9);
  assign opnd = d[10:0];
  assign vector_addr = d;
  assign low_wr_data = d[7:0];
  assign latch_wr_data = d[4:0];
endmodule

/* File: sim/pcstk_chk.sv */
// assertions on the ports of the program counter block
`timescale 1ns/1ps
`include "pcstk_consts.vh"
module pcstk_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire step,
  input wire call_instr,
  input wire unconditional_jump_instr,
  input wire [10:0] opnd,
  input wire irq_vector,
  input wire [12:0] vector_addr,
  input wire return_instr,
  input wire exit_with_literal_instr,
  input wire interrupt_exit_instr,
  input wire low_wr,
  input wire [7:0] low_wr_data,
  input wire latch_wr,
  input wire [12:0] fetch_addr,
  input wire [7:0] pc_low_byte,
  input wire [4:0] pc_high_latch
);
  wire pop = return_instr | exit_with_literal_instr | interrupt_exit_instr;
  wire jmp = call_instr | unconditional_jump_instr | irq_vector | low_wr | pop;
  reg run_m; // mirror of the run enable in the control register
  wire solo = !psel && !irq_vector && run_m; // no bus, vector or halt in the way
  reg [12:0] push_r; // fetch address at the last step, jump, call, vector, low write or return op
  reg pushed_r; // last of those decoder ops was a call
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_r <= 13'h0000;
      pushed_r <= 1'b0;
    end else if (jmp | step) begin
      push_r <= fetch_addr;
      pushed_r <= call_instr;
    end
  end
  // run enable follows bus writes to the control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_m <= 1'b1;
    end else if (psel && penable && pwrite && paddr == `PCSTK_OFF_CTRL) begin
      run_m <= pwdata[`PCSTK_CTRL_RUN];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_call_load: assert property (call_instr && solo |=>
    fetch_addr == {$past(pc_high_latch[4:3]), $past(opnd)}) else $error("call load");
  a_jump_load: assert property (unconditional_jump_instr && !call_instr && solo |=>
    fetch_addr == {$past(pc_high_latch[4:3]), $past(opnd)}) else $error("jump load");
  a_low_load: assert property (low_wr && !call_instr && !unconditional_jump_instr && solo |=>
    fetch_addr == {$past(pc_high_latch), $past(low_wr_data)}) else $error("low load");
  a_step_inc: assert property (step && !jmp && !psel && run_m |=>
    fetch_addr == $past(fetch_addr) + 13'h0001) else $error("step");
  a_low_mirror: assert property (pc_low_byte == fetch_addr[7:0]) else $error("mirror");
  a_latch_kept: assert property ((call_instr || pop) && !latch_wr && !psel |=>
    $stable(pc_high_latch)) else $error("latch moved");
  a_pop_value: assert property (pop && pushed_r && solo |=>
    $stable(fetch_addr) ##1 fetch_addr == $past(push_r, 2)) else $error("pop");
  a_vector_load: assert property (irq_vector && !psel && run_m |=>
    fetch_addr == $past(vector_addr)) else $error("vector");
  a_bus_ready: assert property (psel && !penable |=> pready) else $error("ready");
endmodule
bind pcstk_top pcstk_chk u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .step(step),
  .call_instr(call_instr),
  .unconditional_jump_instr(unconditional_jump_instr),
  .opnd(opnd),
  .irq_vector(irq_vector),
  .vector_addr(vector_addr),
  .return_instr(return_instr),
  .exit_with_literal_instr(exit_with_literal_instr),
  .interrupt_exit_instr(interrupt_exit_instr),
  .low_wr(low_wr),
  .low_wr_data(low_wr_data),
  .latch_wr(latch_wr),
  .fetch_addr(fetch_addr),
  .pc_low_byte(pc_low_byte),
  .pc_high_latch(pc_high_latch)
);

/* File: sim/tb.sv */
// bench: bus and decoder sequences against a reference model
`timescale 1ns/1ps
`include "pcstk_consts.vh"
module tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg [3:0] op = 4'h0;
  reg [12:0] arg = 13'h0000;
  wire [31:0] prdata;
  wire pready, pslverr, step, call_instr, unconditional_jump_instr, irq_vector;
  wire return_instr, exit_with_literal_instr, interrupt_exit_instr, low_wr, latch_wr;
  wire [10:0] opnd;
  wire [12:0] vector_addr, fetch_addr;
  wire [7:0] low_wr_data, pc_low_byte;
  wire [4:0] latch_wr_data, pc_high_latch;
  integer bad_count = 0, checked = 0, cyc = 0, i;
  reg [12:0] stk [0:7]; // reference return stack
  reg [2:0] sp = 3'h0;
  reg [12:0] pc = 13'h0000;
  reg [4:0] lat = 5'h00;
  reg [31:0] rd;
  reg err;
  reg run_m = 1'b1; // model of the run enable
  reg [3:0] pop_op; // which of the three return kinds to send
  pcstk_top uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .step(step),
    .call_instr(call_instr),
    .unconditional_jump_instr(unconditional_jump_instr),
    .opnd(opnd),
    .irq_vector(irq_vector),
    .vector_addr(vector_addr),
    .return_instr(return_instr),
    .exit_with_literal_instr(exit_with_literal_instr),
    .interrupt_exit_instr(interrupt_exit_instr),
    .low_wr(low_wr),
    .low_wr_data(low_wr_data),
    .latch_wr(latch_wr),
    .latch_wr_data(latch_wr_data),
    .fetch_addr(fetch_addr),
    .pc_low_byte(pc_low_byte),
    .pc_high_latch(pc_high_latch)
  );
  pcstk_dec dec (
    .op(op),
    .arg(arg),
    .step(step),
    .call_instr(call_instr),
    .unconditional_jump_instr(unconditional_jump_instr),
    .opnd(opnd),
    .irq_vector(irq_vector),
    .vector_addr(vector_addr),
    .return_instr(return_instr),
    .exit_with_literal_instr(exit_with_literal_instr),
    .interrupt_exit_instr(interrupt_exit_instr),
    .low_wr(low_wr),
    .low_wr_data(low_wr_data),
    .latch_wr(latch_wr),
    .latch_wr_data(latch_wr_data)
  );
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task dop(input [3:0] c, input [12:0] a);
    begin
      @(posedge pclk);
      op <= c;
      arg <= a;
      @(posedge pclk);
      op <= 4'h0;
      if (c >= 4'h5 && c <= 4'h7) begin
        if (run_m) begin
          sp = sp - 3'h1;
          pc = stk[sp];
        end
        @(posedge pclk);
      end else if (run_m || c == 4'h9) begin
        if (c == 4'h2 || c == 4'h4) begin
          stk[sp] = pc;
          sp = sp + 3'h1;
        end
        case (c)
          4'h1: pc = pc + 13'h0001;
          4'h2, 4'h3: pc = {lat[4:3], a[10:0]};
          4'h4: pc = a;
          4'h8: pc = {lat, a[7:0]};
          default: lat = a[4:0];
        endcase
      end
      #1;
      chk(fetch_addr, pc);
      chk(pc_low_byte, pc[7:0]);
      chk(pc_high_latch, lat);
    end
  endtask
  task final_report;
    begin
      if (bad_count == 0 && checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    chk(fetch_addr, 32'h0);
    presetn <= 1'b1;
    apb(1'b1, `PCSTK_OFF_LATCH, 32'h15);
    lat = 5'h15;
    apb(1'b0, `PCSTK_OFF_LATCH, 32'h0);
    chk(rd, 32'h15);
    apb(1'b1, `PCSTK_OFF_LOW, 32'hFF);
    pc = 13'h15FF;
    apb(1'b0, `PCSTK_OFF_LOW, 32'h0);
    chk(rd, 32'hFF);
    chk(fetch_addr, pc);
    dop(4'h1, 13'h0000);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    dop(4'h3, 13'h07A5);
    dop(4'h4, 13'h0004);
    for (i = 0; i < 9; i = i + 1) dop(4'h2, {i[4:0], 8'h3C});
    dop(4'h9, 13'h000A);
    dop(4'h8, 13'h005C);
    for (i = 0; i < 10; i = i + 1) begin
      pop_op = (i % 3 == 0) ? 4'h5 : ((i % 3 == 1) ? 4'h6 : 4'h7);
      dop(pop_op, 13'h0000);
    end
    apb(1'b0, `PCSTK_OFF_STAT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `PCSTK_OFF_CTRL, 32'h0);
    run_m = 1'b0;
    apb(1'b0, `PCSTK_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    dop(4'h1, 13'h0000);
    dop(4'h3, 13'h0123);
    dop(4'h9, 13'h0011);
    apb(1'b1, `PCSTK_OFF_CTRL, 32'h1);
    run_m = 1'b1;
    apb(1'b1, `PCSTK_OFF_CTRL, 32'h3);
    @(posedge pclk);
    #1;
    pc = 13'h0000;
    lat = 5'h00;
    sp = 3'h0;
    chk({fetch_addr, pc_high_latch}, 32'h0);
    dop(4'h1, 13'h0000);
    dop(4'h2, 13'h0456);
    dop(4'h5, 13'h0000);
    final_report;
  end
endmodule
